// [logic/xcl_host.sv]
// Host end: streams 16-bit row words out as a 256-bit frame.
`timescale 1ns/10ps
module xcl_host import xcl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Row words, row fifteen first; bit 15 is column fifteen
  input wire logic [XCL_WORD_W-1:0] row_data,
  input wire logic row_valid,
  output logic row_ready,
  // Status
  output logic busy,
  output logic frame_done,
  output logic chain_echo,
  // Link side
  xcl_link_if.host link
);
  // ----------------------------------------------------------------
  // Frame sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    XCL_IDLE = 3'b000,
    XCL_FETCH = 3'b001,
    XCL_SETUP = 3'b010,
    XCL_HIGH = 3'b011,
    XCL_PAUSE = 3'b100,
    XCL_STROBE = 3'b101
  } xcl_state_e;
  xcl_state_e st_r;
  logic [XCL_WORD_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  // ----------------------------------------------------------------
  // Row word queue
  // ----------------------------------------------------------------
  xcl_fifo #(.WIDTH(XCL_WORD_W), .DEPTH(XCL_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_data(row_data),
    .in_valid(row_valid),
    .in_ready(row_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
  // ----------------------------------------------------------------
  // Half-period timer and decodes
  // ----------------------------------------------------------------
  logic [7:0] div_r;
  logic [XCL_CNT_W-1:0] bit_r;
  logic [XCL_WORD_W-1:0] word_r;
  logic sclk_r;
  logic sdo_r;
  logic tn_r;
  logic done_r;
  logic [1:0] echo_sync_r;
  logic tick;
  logic rise_now;
  logic fall_now;
  logic word_end;
  logic frame_end;
  logic strobe_go;
  logic strobe_end;
  logic take_word;
  assign tick = (div_r == '0);
  assign rise_now = (st_r == XCL_SETUP) && tick;
  assign fall_now = (st_r == XCL_HIGH) && tick;
  assign word_end = (bit_r[3:0] == XCL_WORD_LAST);
  assign frame_end = (bit_r == XCL_LAST_BIT);
  assign strobe_go = (st_r == XCL_PAUSE) && tick;
  assign strobe_end = (st_r == XCL_STROBE) && tick;
  // A word is only taken on a falling tick or on a tick in FETCH, so a dry FIFO
  // merely stretches the low phase; keep it fed at 312.5 kHz or more.
  assign f_ready = tick && ((st_r == XCL_FETCH) ||
                   ((st_r == XCL_HIGH) && word_end && !frame_end));
  assign take_word = f_ready && f_valid;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_r <= '0;
    end else if (strobe_go) begin
      div_r <= XCL_STROBE_CNT;
    end else begin
      div_r <= tick ? XCL_HALF_CNT : div_r - 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Data changes only on a falling tick or while waiting with the
  // clock low, so it has a full half period of setup and hold.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= XCL_IDLE;
    end else begin
      case (st_r)
        XCL_IDLE: begin
          if (f_valid) begin
            st_r <= XCL_FETCH;
          end
        end
        XCL_FETCH: begin
          if (take_word) begin
            st_r <= XCL_SETUP;
          end
        end
        XCL_SETUP: begin
          if (tick) begin
            st_r <= XCL_HIGH;
          end
        end
        XCL_HIGH: begin
          if (tick) begin
            if (frame_end) begin
              st_r <= XCL_PAUSE;
            end else if (word_end && !f_valid) begin
              st_r <= XCL_FETCH;
            end else begin
              st_r <= XCL_SETUP;
            end
          end
        end
        XCL_PAUSE: begin
          if (tick) begin
            st_r <= XCL_STROBE;
          end
        end
        XCL_STROBE: begin
          if (tick) begin
            st_r <= XCL_IDLE;
          end
        end
        default: begin
          st_r <= XCL_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bit_r <= '0;
    end else if (st_r == XCL_IDLE) begin
      bit_r <= '0;
    end else if (fall_now) begin
      bit_r <= bit_r + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Serial data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      word_r <= '0;
    end else if (take_word) begin
      word_r <= {f_data[XCL_WORD_W-2:0], 1'b0};
    end else if (fall_now) begin
      word_r <= {word_r[XCL_WORD_W-2:0], 1'b0};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sdo_r <= 1'b0;
    end else if (take_word) begin
      sdo_r <= f_data[XCL_WORD_W-1];
    end else if (fall_now && !word_end) begin
      sdo_r <= word_r[XCL_WORD_W-1];
    end
  end
  // ----------------------------------------------------------------
  // Serial clock and transfer strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sclk_r <= 1'b0;
    end else if (rise_now) begin
      sclk_r <= 1'b1;
    end else if (fall_now) begin
      sclk_r <= 1'b0;
    end
  end
  // The strobe waits a half period after the last fall of the clock.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tn_r <= 1'b1;
    end else if (strobe_go) begin
      tn_r <= 1'b0;
    end else if (strobe_end) begin
      tn_r <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= strobe_end;
    end
  end
  // ----------------------------------------------------------------
  // Echo and status
  // ----------------------------------------------------------------
  // Serial out comes from the other end; two flops before use.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      echo_sync_r <= '0;
    end else begin
      echo_sync_r <= {echo_sync_r[0], link.serial_config_out};
    end
  end
  logic busy_r;
  logic echo_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      echo_r <= 1'b0;
    end else begin
      busy_r <= (st_r != XCL_IDLE);
      echo_r <= echo_sync_r[1];
    end
  end
  assign busy = busy_r;
  assign frame_done = done_r;
  assign chain_echo = echo_r;
  assign link.serial_clk = sclk_r;
  assign link.serial_config_in = sdo_r;
  assign link.transfer_n = tn_r;
endmodule

// [logic/xcl_pkg.sv]
// Shared constants for the crosspoint configuration loader link.
package xcl_pkg;
  // --------------------------------------------------------------
  // Array geometry
  // --------------------------------------------------------------
  localparam int XCL_ROWS = 16;
  localparam int XCL_COLS = 16;
  localparam int XCL_BITS = 256;
  localparam int XCL_CNT_W = 9;
  localparam logic [XCL_CNT_W-1:0] XCL_LAST_BIT = 9'h0FF;
  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int XCL_SYS_CLK_MHZ = 100;
  // Serial clock divider: half period in system clocks (5 MHz link).
  localparam int XCL_HALF_NS = 100;
  localparam int XCL_HALF_CYC = (XCL_HALF_NS * XCL_SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] XCL_HALF_CNT = 8'(XCL_HALF_CYC - 1);
  // Transfer strobe low width, 65 ns least.
  localparam int XCL_STROBE_NS = 65;
  localparam int XCL_STROBE_CYC =
    (XCL_STROBE_NS * XCL_SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] XCL_STROBE_CNT = 8'(XCL_STROBE_CYC);
  // Word width of the host stream and host FIFO depth.
  localparam int XCL_WORD_W = 16;
  localparam int XCL_FIFO_DEPTH = 8;
  localparam logic [3:0] XCL_WORD_LAST = 4'hF;
endpackage

// [logic/xcl_link_if.sv]
// Serial link between the configuration host and the switch array.
`timescale 1ns/10ps
interface xcl_link_if;
  logic serial_clk;
  logic serial_config_in;
  logic transfer_n;
  logic serial_config_out;
  modport host (
    output serial_clk,
    output serial_config_in,
    output transfer_n,
    input serial_config_out
  );
  modport dev (
    input serial_clk,
    input serial_config_in,
    input transfer_n,
    output serial_config_out
  );
endinterface

// [logic/xcl_fifo.sv]
// Synchronous valid/ready FIFO.
`timescale 1ns/10ps
module xcl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic in_ready_r;
  logic push;
  logic pop;
  // Registered so that the fill side sees a flop, not a compare.
  assign in_ready = in_ready_r;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule

// [logic/xcl_dev.sv]
// Device end: serial shift chain and static switch latches.
`timescale 1ns/10ps
module xcl_dev import xcl_pkg::*; (
  // Link side
  xcl_link_if.dev link,
  // Switch array side, index row*16+column
  output logic [XCL_BITS-1:0] switch_closed
);
  // ----------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------
  // Bit 0 takes the newest bit; after 256 clocks the first bit sent
  // (row fifteen, column fifteen) sits at the top index.
  logic [XCL_BITS-1:0] chain_r;
  logic serial_config_out_r;
  always_ff @(posedge link.serial_clk) begin
    chain_r <= {chain_r[XCL_BITS-2:0], link.serial_config_in};
  end
  always_ff @(posedge link.serial_clk) begin
    serial_config_out_r <= chain_r[XCL_BITS-1];
  end
  assign link.serial_config_out = serial_config_out_r;
  // ----------------------------------------------------------------
  // Static latches
  // ----------------------------------------------------------------
  // The strobe is a level-sensitive transfer in the part; here its
  // falling edge clocks the copy, and the latches then hold until the next fall.
  logic [XCL_BITS-1:0] latch_r;
  always_ff @(negedge link.transfer_n) begin
    latch_r <= chain_r;
  end
  assign switch_closed = latch_r;
endmodule

// [dv/xcl_sva.sv]
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/10ps
module xcl_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  input wire logic serial_clk,
  input wire logic serial_config_in,
  input wire logic transfer_n,
  input wire logic serial_config_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sclk_high_a: assert property ($rose(serial_clk) |=> serial_clk [*8])
    else $error("serial clock high phase too short");
  sclk_low_a: assert property ($fell(serial_clk) |=> !serial_clk [*8])
    else $error("serial clock low phase too short");
  sclk_rate_a: assert property (
    $rose(serial_clk) |-> ##[9:30] $fell(serial_clk))
    else $error("serial clock stuck high");
  data_hold_a: assert property (
    serial_clk && $past(serial_clk) |-> $stable(serial_config_in))
    else $error("serial data moved while clock high");
  strobe_quiet_a: assert property (
    $fell(transfer_n) |-> (!serial_clk && !transfer_n) [*6])
    else $error("strobe too short or clock moved");
  strobe_len_a: assert property (
    $fell(transfer_n) |-> ##[6:20] transfer_n)
    else $error("strobe not returned high");
  strobe_after_a: assert property (
    $fell(transfer_n) |-> !$past(serial_clk))
    else $error("strobe began with clock high");
  out_edge_a: assert property (
    $changed(serial_config_out) |-> $rose(serial_clk))
    else $error("serial output moved off a clock rise");
  cover property ($fell(transfer_n));
  cover property ($rose(serial_clk) && serial_config_in);
  cover property ($changed(serial_config_out));
endmodule

// [dv/crosspoint_switch_config_loader_tb_top.sv]
// Testbench: host end streams frames into the device end over the link.
`timescale 1ns/10ps
module crosspoint_switch_config_loader_tb_top;
  import xcl_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [XCL_WORD_W-1:0] row_data = 16'h0000;
  logic row_valid = 1'b0;
  logic row_ready, busy, frame_done, chain_echo;
  logic [XCL_BITS-1:0] switch_closed;
  logic [XCL_WORD_W-1:0] rows [XCL_ROWS];
  int error_cnt = 0;
  int compares = 0;
  logic [XCL_BITS-1:0] prev_sw;
  logic prev_ok = 1'b0;
  int pos = 0;
  xcl_link_if lnk ();
  xcl_host i_xcl_host (.sys_clk(sys_clk), .resetn(resetn),
    .row_data(row_data), .row_valid(row_valid), .row_ready(row_ready),
    .busy(busy), .frame_done(frame_done), .chain_echo(chain_echo),
    .link(lnk));
  xcl_dev i_xcl_dev (.link(lnk), .switch_closed(switch_closed));
  xcl_sva i_xcl_sva (.sys_clk(sys_clk), .resetn(resetn),
    .serial_clk(lnk.serial_clk), .serial_config_in(lnk.serial_config_in),
    .transfer_n(lnk.transfer_n),
    .serial_config_out(lnk.serial_config_out));
  always #5 sys_clk = ~sys_clk;
  // Serial out replays the previous frame, first bit sent first; the
  // reset-time settling of the clock pin is not a shift.
  always @(negedge lnk.serial_clk) begin
    #1;
    if (resetn) begin
      if (prev_ok) begin
        cmp_bit(chain_echo, prev_sw[XCL_BITS-1-pos], "chain echo");
      end
      pos = (pos + 1) % XCL_BITS;
    end
  end
  // Row r, column c lands at index r*16+c; one means closed.
  function automatic logic [XCL_BITS-1:0] expect_sw();
    logic [XCL_BITS-1:0] v;
    for (int r = 0; r < XCL_ROWS; r++) v[r*XCL_COLS +: XCL_COLS] = rows[r];
    return v;
  endfunction
  task final_report();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    $display("mismatch at %0t: %s", $time, m);
    error_cnt++;
  endtask
  task automatic cmp_vec(input logic [XCL_BITS-1:0] got, exp,
                         input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask
  task automatic cmp_bit(input logic got, exp, input string m);
    compares++;
    if (got !== exp) fail(m);
  endtask
  // Sampled at the falling edge, where row_ready and frame_done have settled.
  task wait_flag(input bit done);
    int n;
    n = 0;
    @(negedge sys_clk);
    while ((done ? frame_done : row_ready) !== 1'b1 && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 9000) begin
      fail("handshake timed out");
      final_report();
    end
  endtask
  initial begin
    void'($urandom(55402));
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1'b1;
    for (int f = 0; f < 5; f++) begin
      for (int r = XCL_ROWS - 1; r >= 0; r--) begin
        case (f)
          0: rows[r] = 16'h0000;
          1: rows[r] = 16'hFFFF;
          2: rows[r] = 16'h0001 << r;
          default: rows[r] = 16'($urandom);
        endcase
        // Gaps drop row_valid between rows; the FIFO never runs dry mid-frame.
        if (f == 4) begin
          row_valid = 1'b0;
          repeat ($urandom_range(30)) @(posedge sys_clk);
          #1;
        end
        row_data = rows[r];
        row_valid = 1'b1;
        wait_flag(1'b0);
        @(posedge sys_clk);
        #1;
      end
      row_valid = 1'b0;
      wait_flag(1'b1);
      cmp_bit(busy, 1'b1, "busy low at frame end");
      cmp_vec(switch_closed, expect_sw(), "latches after frame");
      prev_sw = expect_sw();
      prev_ok = 1'b1;
      repeat (40) @(posedge sys_clk);
      #1;
      cmp_vec(switch_closed, expect_sw(), "latches did not hold");
      cmp_bit(busy, 1'b0, "busy stuck after frame");
    end
    final_report();
  end
endmodule
